/* File: ecd_top.sv */
// configuration word loader and power-management decoder
// Function
// - suppress bit one: D3_hot to D0 by software keeps context, no internal reset
// - suppress bit zero: D3_hot to D0 by software does internal reset
// - suppress bit copied into bit 3 of control/status register
// - bus reset in D3_hot returns D0 uninitialized, keeps only enabled wake context
// - word bit 12 with wake enable asserts wake in D2; copied to capability bit 13
// - word bit 11 with wake enable asserts wake in D1; copied to capability bit 12
// - word bit 10 (D2 supported) copied to capability bit 10
// - word bit 9 (D1 supported) copied to capability bit 9
// - word bit 1 picks clock rate: zero 125 MHz, one 25 MHz
// - after power-up run at 125 MHz; lower only via loaded bit
// - with eeprom present pin high, read words 0 to 6 after reset
// - the configuration word is eeprom word 6
// - word bit 0 selects async bus width, copied to capability bit 0
`timescale 1ns/1ps
`default_nettype none
module ecd_top #(
	parameter int SOFT_RST_CYCLES = ecd_pkg::SOFT_RST_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// eeprom word reader
	input wire logic eeprom_present_pin,
	output logic ee_rd_req,
	output logic [5:0] ee_rd_addr,
	input wire logic ee_rd_valid,
	input wire logic [15:0] ee_rd_data,
	// power management
	input wire logic bus_seg_reset,
	input wire logic wake_source,
	output logic wake_event,
	output logic soft_reset_out,
	output logic clk_rate_slow,
	output logic async_bus_16,
	output logic load_done,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// interrupt
	output logic irq
);

	// ----------------------------------------------------------------
	// pin synchroniser: three stages, change taken when 2 and 3 agree
	// ----------------------------------------------------------------
	logic [2:0] een_sync_ff;
	logic een_filt_ff;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			een_sync_ff <= 3'h0;
			een_filt_ff <= 1'b0;
		end else begin
			een_sync_ff <= {een_sync_ff[1:0], eeprom_present_pin};
			if (een_sync_ff[1] == een_sync_ff[2]) begin
				een_filt_ff <= een_sync_ff[2];
			end
		end
	end

	logic [2:0] wsrc_sync_ff;
	logic wsrc_filt_ff;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wsrc_sync_ff <= 3'h0;
			wsrc_filt_ff <= 1'b0;
		end else begin
			wsrc_sync_ff <= {wsrc_sync_ff[1:0], wake_source};
			if (wsrc_sync_ff[1] == wsrc_sync_ff[2]) begin
				wsrc_filt_ff <= wsrc_sync_ff[2];
			end
		end
	end

	logic [2:0] bres_sync_ff;
	logic bres_filt_ff;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bres_sync_ff <= 3'h0;
			bres_filt_ff <= 1'b0;
		end else begin
			bres_sync_ff <= {bres_sync_ff[1:0], bus_seg_reset};
			if (bres_sync_ff[1] == bres_sync_ff[2]) begin
				bres_filt_ff <= bres_sync_ff[2];
			end
		end
	end

	// ----------------------------------------------------------------
	// loader state machine
	// ----------------------------------------------------------------
	// the pin is sampled a few cycles after release so the filter has settled
	ecd_pkg::ecd_load_t ld_ff;
	ecd_pkg::ecd_load_t nxt_ld;
	logic [5:0] word_ff;
	logic [2:0] settle_ff;
	logic [15:0] cfg_word_ff;
	logic cfg_valid_ff;

	wire settled = (settle_ff == 3'h7);
	wire word_take = (ld_ff == ecd_pkg::LD_WAIT) && ee_rd_valid;
	wire last_word = (word_ff == ecd_pkg::WORD_LAST);

	always_comb begin
		nxt_ld = ld_ff;
		case (ld_ff)
			ecd_pkg::LD_IDLE: begin
				if (settled) begin
					nxt_ld = een_filt_ff ? ecd_pkg::LD_REQ : ecd_pkg::LD_DONE;
				end
			end
			ecd_pkg::LD_REQ: nxt_ld = ecd_pkg::LD_WAIT;
			ecd_pkg::LD_WAIT: begin
				if (ee_rd_valid) begin
					nxt_ld = last_word ? ecd_pkg::LD_DONE : ecd_pkg::LD_REQ;
				end
			end
			ecd_pkg::LD_DONE: nxt_ld = ecd_pkg::LD_DONE;
			default: nxt_ld = ecd_pkg::LD_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ld_ff <= ecd_pkg::LD_IDLE;
			word_ff <= ecd_pkg::WORD_FIRST;
			settle_ff <= 3'h0;
		end else begin
			ld_ff <= nxt_ld;
			if (!settled) begin
				settle_ff <= settle_ff + 3'h1;
			end
			if (word_take && !last_word) begin
				word_ff <= word_ff + 6'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cfg_word_ff <= 16'h0000;
			cfg_valid_ff <= 1'b0;
		end else if (word_take && word_ff == ecd_pkg::WORD_CONFIG) begin
			cfg_word_ff <= ee_rd_data;
			cfg_valid_ff <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ee_rd_req <= 1'b0;
			ee_rd_addr <= 6'h00;
			load_done <= 1'b0;
		end else begin
			ee_rd_req <= (nxt_ld == ecd_pkg::LD_REQ);
			ee_rd_addr <= (word_take && !last_word) ? word_ff + 6'h01 : word_ff;
			load_done <= (nxt_ld == ecd_pkg::LD_DONE);
		end
	end

	// fetched words, readable by the host
	logic [15:0] mem_rdata;
	ecd_word_mem #(.DEPTH(8), .AW(3)) u_mem (
		.sys_clk(sys_clk),
		.wr_en(word_take),
		.wr_addr(word_ff[2:0]),
		.wr_data(ee_rd_data),
		.rd_addr(reg_addr[2:0]),
		.rd_data(mem_rdata)
	);

	ecd_pkg::ecd_cfg_t cfg;
	ecd_cfg_decode u_dec (
		.cfg_word(cfg_word_ff),
		.cfg(cfg)
	);

	// ----------------------------------------------------------------
	// power state and soft reset
	// ----------------------------------------------------------------
	logic [15:0] cap_ff;
	logic [15:0] power_mgmt_ctrl_status_ff;
	logic [3:0] mask_ff;
	logic [3:0] status_ff;
	logic [7:0] srst_cnt_ff;

	wire wr_cap = reg_wr && (reg_addr == ecd_pkg::OFS_CAPABILITY);
	wire wr_power_mgmt_ctrl_status = reg_wr && (reg_addr == ecd_pkg::OFS_CTRL_STATUS);
	wire wr_stat = reg_wr && (reg_addr == ecd_pkg::OFS_STATUS);
	wire wr_mask = reg_wr && (reg_addr == ecd_pkg::OFS_MASK);
	wire [1:0] cur_ps = power_mgmt_ctrl_status_ff[1:0];
	wire [1:0] new_ps = reg_wdata[1:0];
	wire wake_en = power_mgmt_ctrl_status_ff[ecd_pkg::POWER_MGMT_CTRL_STATUS_WAKE_EN_BIT];
	wire d3_to_d0 = wr_power_mgmt_ctrl_status && cur_ps == ecd_pkg::PS_D3 && new_ps == ecd_pkg::PS_D0;
	wire soft_rst_ev = d3_to_d0 && !cfg.soft_reset_suppress;
	wire bus_rst_ev = bres_filt_ff && cur_ps == ecd_pkg::PS_D3;
	wire [15:0] power_mgmt_ctrl_status_wr_val = {reg_wdata[15:4], cfg.soft_reset_suppress, reg_wdata[2:0]};
	// a bus reset clears all but the wake enable, and that only if wake is supported
	wire wake_sup = cap_ff[ecd_pkg::CAP_WAKE_D1_BIT] | cap_ff[ecd_pkg::CAP_WAKE_D2_BIT];
	wire [15:0] keep_wake = {7'h00, wake_en & wake_sup, 8'h00};
	wire wake_now = wake_en && wsrc_filt_ff
		&& ((cur_ps == ecd_pkg::PS_D2 && cap_ff[ecd_pkg::CAP_WAKE_D2_BIT])
		|| (cur_ps == ecd_pkg::PS_D1 && cap_ff[ecd_pkg::CAP_WAKE_D1_BIT]));

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			power_mgmt_ctrl_status_ff <= ecd_pkg::CTRL_STATUS_RST;
		end else if (bus_rst_ev) begin
			power_mgmt_ctrl_status_ff <= keep_wake;
		end else if (soft_rst_ev) begin
			power_mgmt_ctrl_status_ff <= {12'h000, cfg.soft_reset_suppress, 3'h0};
		end else if (wr_power_mgmt_ctrl_status) begin
			power_mgmt_ctrl_status_ff <= power_mgmt_ctrl_status_wr_val;
		end else if (cfg_valid_ff) begin
			power_mgmt_ctrl_status_ff[ecd_pkg::POWER_MGMT_CTRL_STATUS_SRST_BIT] <= cfg.soft_reset_suppress;
		end
	end

	// capability register: loaded from the word, software cannot change loaded bits
	wire [15:0] cap_load = {2'h0, cfg.wake_in_d2_allow, cfg.wake_in_d1_allow,
		1'b0, cfg.d2_state_supported, cfg.d1_state_supported, 8'h00,
		cfg.async_bus_width_select};

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cap_ff <= ecd_pkg::CAPABILITY_RST;
		end else begin
			cap_ff <= cap_load;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			srst_cnt_ff <= 8'h00;
		end else if (soft_rst_ev) begin
			srst_cnt_ff <= 8'(SOFT_RST_CYCLES);
		end else if (srst_cnt_ff != 8'h00) begin
			srst_cnt_ff <= srst_cnt_ff - 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status: set wins over write-one-to-clear
	// ----------------------------------------------------------------
	wire [3:0] ev_vec = {wake_now, bus_rst_ev, soft_rst_ev, load_done & ~status_ff[0]};
	logic load_seen_ff;
	wire [3:0] ev_set = {ev_vec[3:1], ev_vec[0] & ~load_seen_ff};
	wire [3:0] stat_clr = wr_stat ? reg_wdata[3:0] : 4'h0;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			status_ff <= 4'h0;
			mask_ff <= ecd_pkg::MASK_RST;
			load_seen_ff <= 1'b0;
			irq <= 1'b0;
		end else begin
			status_ff <= (status_ff & ~stat_clr) | ev_set;
			if (wr_mask) begin
				mask_ff <= reg_wdata[3:0];
			end
			load_seen_ff <= load_seen_ff | load_done;
			irq <= |(((status_ff & ~stat_clr) | ev_set) & mask_ff);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wake_event <= 1'b0;
			soft_reset_out <= 1'b0;
			clk_rate_slow <= 1'b0;
			async_bus_16 <= 1'b0;
		end else begin
			wake_event <= wake_now;
			soft_reset_out <= soft_rst_ev || (srst_cnt_ff > 8'h01);
			clk_rate_slow <= cfg.clk_slow;
			async_bus_16 <= cfg.async_bus_width_select;
		end
	end

	// ----------------------------------------------------------------
	// register read, data one cycle after the strobe
	// ----------------------------------------------------------------
	logic rd_mem_ff;
	logic [15:0] rd_reg_ff;
	wire [15:0] rd_mux = (reg_addr == ecd_pkg::OFS_CAPABILITY) ? cap_ff :
		(reg_addr == ecd_pkg::OFS_CTRL_STATUS) ? power_mgmt_ctrl_status_ff :
		(reg_addr == ecd_pkg::OFS_STATUS) ? {12'h000, status_ff} :
		(reg_addr == ecd_pkg::OFS_MASK) ? {12'h000, mask_ff} :
		(reg_addr == ecd_pkg::OFS_CONTROL) ? {15'h0000, load_done} : 16'h0000;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rd_mem_ff <= 1'b0;
			rd_reg_ff <= 16'h0000;
		end else begin
			rd_mem_ff <= reg_rd && reg_addr[3];
			rd_reg_ff <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// memory read data is already registered, so only a select follows
	assign reg_rdata = rd_mem_ff ? mem_rdata : rd_reg_ff;

	logic unused_ok;
	// the capability offset is read-only, so its write decode goes nowhere
	assign unused_ok = &{1'b0, wr_cap};

endmodule : ecd_top
`default_nettype wire

/* File: ecd_pkg.sv */
// package: constants, types and register map of the configuration word decoder
package ecd_pkg;

	// ----------------------------------------------------------------
	// eeprom word layout
	// ----------------------------------------------------------------
	localparam logic [5:0] WORD_FIRST = 6'h00;
	localparam logic [5:0] WORD_LAST = 6'h06;
	localparam logic [5:0] WORD_CONFIG = 6'h06;
	localparam int CFG_ASYNC_BIT = 0;
	localparam int CFG_CLK_BIT = 1;
	localparam int CFG_D1_STATE_SUPPORTED_BIT = 9;
	localparam int CFG_D2_STATE_SUPPORTED_BIT = 10;
	localparam int CFG_WAKE_D1_BIT = 11;
	localparam int CFG_WAKE_D2_BIT = 12;
	localparam int CFG_SRST_BIT = 14;

	// ----------------------------------------------------------------
	// destination bit positions
	// ----------------------------------------------------------------
	localparam int CAP_ASYNC_BIT = 0;
	localparam int CAP_D1_STATE_SUPPORTED_BIT = 9;
	localparam int CAP_D2_STATE_SUPPORTED_BIT = 10;
	localparam int CAP_WAKE_D1_BIT = 12;
	localparam int CAP_WAKE_D2_BIT = 13;
	localparam int POWER_MGMT_CTRL_STATUS_SRST_BIT = 3;
	localparam int POWER_MGMT_CTRL_STATUS_WAKE_EN_BIT = 8;

	// ----------------------------------------------------------------
	// register map (word offsets on the plain port)
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CAPABILITY = 4'h0;
	localparam logic [3:0] OFS_CTRL_STATUS = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_MASK = 4'h3;
	localparam logic [3:0] OFS_CONTROL = 4'h4;
	localparam logic [3:0] OFS_WORD_BASE = 4'h8;
	localparam logic [15:0] CAPABILITY_RST = 16'h0000;
	localparam logic [15:0] CTRL_STATUS_RST = 16'h0000;
	localparam logic [3:0] MASK_RST = 4'h0;

	// status/mask bit positions
	localparam int EV_LOAD_DONE = 0;
	localparam int EV_SOFT_RESET = 1;
	localparam int EV_BUS_RESET = 2;
	localparam int EV_WAKE = 3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int SOFT_RST_NS = 100;
	localparam int SOFT_RST_CYC = (SOFT_RST_NS * (CLK_HZ / 1000000) + 999) / 1000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PS_D0 = 2'b00,
		PS_D1 = 2'b01,
		PS_D2 = 2'b10,
		PS_D3 = 2'b11
	} ecd_pstate_t;

	typedef enum logic [1:0] {
		LD_IDLE = 2'b00,
		LD_REQ = 2'b01,
		LD_WAIT = 2'b10,
		LD_DONE = 2'b11
	} ecd_load_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} ecd_bus_t;

	typedef struct packed {
		logic soft_reset_suppress;
		logic wake_in_d2_allow;
		logic wake_in_d1_allow;
		logic d2_state_supported;
		logic d1_state_supported;
		logic clk_slow;
		logic async_bus_width_select;
	} ecd_cfg_t;

endpackage : ecd_pkg

/* File: ecd_word_mem.sv */
// eight-word store of the words fetched at reset, registered read port
`timescale 1ns/1ps
`default_nettype none
module ecd_word_mem #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// clock
	input wire logic sys_clk,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [15:0] wr_data,
	// read side
	input wire logic [AW-1:0] rd_addr,
	output logic [15:0] rd_data
);

	logic [15:0] mem_ff [DEPTH];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
		rd_data <= mem_ff[rd_addr];
	end

endmodule : ecd_word_mem
`default_nettype wire

/* File: ecd_cfg_decode.sv */
// pure decode of the configuration word into its used fields
`timescale 1ns/1ps
`default_nettype none
module ecd_cfg_decode (
	// word in
	input wire logic [15:0] cfg_word,
	// fields out
	output ecd_pkg::ecd_cfg_t cfg
);

	// reserved bits 15, 13 and 8..2 are never looked at
	assign cfg.soft_reset_suppress = cfg_word[ecd_pkg::CFG_SRST_BIT];
	assign cfg.wake_in_d2_allow = cfg_word[ecd_pkg::CFG_WAKE_D2_BIT];
	assign cfg.wake_in_d1_allow = cfg_word[ecd_pkg::CFG_WAKE_D1_BIT];
	assign cfg.d2_state_supported = cfg_word[ecd_pkg::CFG_D2_STATE_SUPPORTED_BIT];
	assign cfg.d1_state_supported = cfg_word[ecd_pkg::CFG_D1_STATE_SUPPORTED_BIT];
	assign cfg.clk_slow = cfg_word[ecd_pkg::CFG_CLK_BIT];
	assign cfg.async_bus_width_select = cfg_word[ecd_pkg::CFG_ASYNC_BIT];

endmodule : ecd_cfg_decode
`default_nettype wire

/* File: ecd_eeprom_model.sv */
// behavioural model of the serial eeprom word source seen by the loader
`timescale 1ns/1ps
`default_nettype none
module ecd_eeprom_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// stored config word and answer delay
	input wire logic [15:0] cfg_word,
	input wire logic [3:0] lat,
	// word reader
	input wire logic ee_rd_req,
	input wire logic [5:0] ee_rd_addr,
	output logic ee_rd_valid,
	output logic [15:0] ee_rd_data
);
	logic busy_ff;
	logic [3:0] cnt_ff;
	logic [5:0] addr_ff;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			busy_ff <= 1'b0;
			cnt_ff <= 4'h0;
			addr_ff <= 6'h00;
			ee_rd_valid <= 1'b0;
			ee_rd_data <= 16'h0000;
		end else begin
			ee_rd_valid <= 1'b0;
			// data toggles between answers so a stale word is never mistaken for a fresh one
			ee_rd_data <= ~ee_rd_data;
			if (ee_rd_req) begin
				busy_ff <= 1'b1;
				cnt_ff <= lat;
				addr_ff <= ee_rd_addr;
			end else if (busy_ff && cnt_ff != 4'h0) begin
				cnt_ff <= cnt_ff - 4'h1;
			end else if (busy_ff) begin
				busy_ff <= 1'b0;
				ee_rd_valid <= 1'b1;
				ee_rd_data <= (addr_ff == 6'h06) ? cfg_word : {10'h040, addr_ff};
			end
		end
	end
endmodule : ecd_eeprom_model
`default_nettype wire

/* File: ecd_top_asserts.sv */
// port-level checks of the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module ecd_top_asserts #(
	parameter int SOFT_RST_CYCLES = 4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// eeprom word reader
	input wire logic ee_rd_req,
	input wire logic [5:0] ee_rd_addr,
	input wire logic ee_rd_valid,
	input wire logic [15:0] ee_rd_data,
	// power management
	input wire logic wake_event,
	input wire logic soft_reset_out,
	input wire logic clk_rate_slow,
	input wire logic async_bus_16,
	input wire logic load_done
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// ----------------------------------------------------------------
	// helper state
	// ----------------------------------------------------------------
	logic pend_ff, cfg_ok_ff;
	logic [5:0] last_ff;
	logic [15:0] cfg_ff;
	int srst_cnt_ff;
	wire word6_taken = ee_rd_valid && pend_ff && ee_rd_addr == 6'h06;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pend_ff <= 1'b0;
			cfg_ok_ff <= 1'b0;
			last_ff <= 6'h00;
			cfg_ff <= 16'h0000;
			srst_cnt_ff <= 0;
		end else begin
			if (ee_rd_req) pend_ff <= 1'b1;
			else if (ee_rd_valid) pend_ff <= 1'b0;
			if (ee_rd_req) last_ff <= ee_rd_addr;
			if (word6_taken) cfg_ff <= ee_rd_data;
			if (word6_taken) cfg_ok_ff <= 1'b1;
			srst_cnt_ff <= soft_reset_out ? srst_cnt_ff + 1 : 0;
		end
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_clk_power_up: assert property (!cfg_ok_ff |-> !clk_rate_slow)
		else $error("clock lowered before config word");
	a_clk_rate_follow: assert property (load_done && $past(load_done) && cfg_ok_ff |-> clk_rate_slow == cfg_ff[1])
		else $error("clock rate differs from word bit 1");
	a_bus_width_follow: assert property (load_done && $past(load_done) && cfg_ok_ff |-> async_bus_16 == cfg_ff[0])
		else $error("bus width differs from word bit 0");
	a_req_ascending: assert property (ee_rd_req |-> ee_rd_addr == 6'h00 || ee_rd_addr == last_ff + 6'h01)
		else $error("word request out of order");
	a_req_in_range: assert property (ee_rd_req |-> ee_rd_addr <= 6'h06)
		else $error("word request beyond word 6");
	a_one_outstanding: assert property (ee_rd_req |-> !pend_ff)
		else $error("second word request while one pending");
	a_done_after_word6: assert property (word6_taken |-> ##[1:4] load_done)
		else $error("load not done after word 6");
	a_wake_needs_bits: assert property (wake_event |-> cfg_ok_ff && (cfg_ff[11] || cfg_ff[12]))
		else $error("wake event without wake permission bit");
	a_srst_suppressed: assert property ($rose(soft_reset_out) |-> !(cfg_ok_ff && cfg_ff[14]))
		else $error("internal reset despite suppress bit");
	a_srst_length: assert property ($fell(soft_reset_out) |-> srst_cnt_ff == SOFT_RST_CYCLES)
		else $error("internal reset pulse of wrong length");
	c_word6: cover property (word6_taken);
	c_srst: cover property ($rose(soft_reset_out));
	c_wake: cover property ($rose(wake_event));
endmodule : ecd_top_asserts
bind ecd_top ecd_top_asserts #(.SOFT_RST_CYCLES(SOFT_RST_CYCLES)) u_ecd_top_asserts (
	.sys_clk(sys_clk), .reset(reset), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
	.ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data), .wake_event(wake_event),
	.soft_reset_out(soft_reset_out), .clk_rate_slow(clk_rate_slow),
	.async_bus_16(async_bus_16), .load_done(load_done));
`default_nettype wire

/* File: eeprom_config_word_decoder_bench.sv */
// self-checking bench of the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module eeprom_config_word_decoder_bench;
	localparam int SRST = 2;
	logic sys_clk, reset, pin, req, valid, bsr, wsrc, wake, srst, slow, a16, done, irq, wr, rd;
	logic [5:0] ra;
	logic [3:0] addr, lat;
	logic [15:0] rdat, wdata, rdata, cw, w, n;
	logic [15:0] words [4] = '{16'hFFFF, 16'hA1FC, 16'h5E03, 16'h1402};
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	ecd_top #(.SOFT_RST_CYCLES(SRST)) u_ecd_top (.sys_clk(sys_clk), .reset(reset),
		.eeprom_present_pin(pin), .ee_rd_req(req), .ee_rd_addr(ra), .ee_rd_valid(valid),
		.ee_rd_data(rdat), .bus_seg_reset(bsr), .wake_source(wsrc), .wake_event(wake),
		.soft_reset_out(srst), .clk_rate_slow(slow), .async_bus_16(a16), .load_done(done),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
		.irq(irq));
	ecd_eeprom_model u_ecd_eeprom_model (.sys_clk(sys_clk), .reset(reset), .cfg_word(cw),
		.lat(lat), .ee_rd_req(req), .ee_rd_addr(ra), .ee_rd_valid(valid), .ee_rd_data(rdat));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input string nm, input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		chk(nm, e, rdata);
	endtask : rd_reg
	task automatic pause(input int c);
		repeat (c) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : pause
	task automatic do_reset(input logic p, input logic [15:0] d, input logic [3:0] l);
		@(posedge sys_clk);
		reset <= 1'b1;
		pin <= p;
		cw <= d;
		lat <= l;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge sys_clk);
		pause(2);
	endtask : do_reset
	task automatic set_ps(input logic [15:0] d, input logic e);
		wr_reg(4'h1, d);
		pause(6);
		chk("wake", {15'h0, e}, {15'h0, wake});
	endtask : set_ps
	function automatic logic [15:0] exp_cap(input logic [15:0] d);
		return {2'b00, d[12], d[11], 1'b0, d[10], d[9], 8'h00, d[0]};
	endfunction : exp_cap
	// ----------------------------------------------------------------
	// main sequence: each word with a different answer delay
	// ----------------------------------------------------------------
	initial begin
		{reset, pin, wsrc, bsr, wr, rd} = 6'b100000;
		{cw, wdata, addr, lat, w, n} = '0;
		foreach (words[i]) begin
			w = words[i];
			do_reset(1'b1, w, 4'(i * 3));
			chk("done", 16'h1, {15'h0, done});
			chk("clk_rate", {15'h0, w[1]}, {15'h0, slow});
			chk("width", {15'h0, w[0]}, {15'h0, a16});
			wr_reg(4'h0, 16'hFFFF);
			rd_reg("cap", 4'h0, exp_cap(w));
			rd_reg("power_mgmt_ctrl_status", 4'h1, {12'h0, w[14], 3'h0});
			rd_reg("word0", 4'h8, 16'h1000);
			rd_reg("word6", 4'hE, w);
			rd_reg("control", 4'h4, 16'h0001);
			rd_reg("unmapped", 4'h5, 16'h0000);
			@(posedge sys_clk) wsrc <= 1'b1;
			set_ps(16'h0102, w[12]);
			set_ps(16'h0101, w[11]);
			set_ps(16'h0002, 1'b0);
			set_ps(16'h0103, 1'b0);
			@(posedge sys_clk) wsrc <= 1'b0;
			wr_reg(4'h1, 16'h0100);
			n = 16'h0;
			repeat (10) begin
				@(negedge sys_clk);
				n = n + 16'(srst);
			end
			chk("srst_cycles", w[14] ? 16'h0 : 16'(SRST), n);
			rd_reg("power_mgmt_ctrl_status", 4'h1, w[14] ? 16'h0108 : 16'h0000);
			wr_reg(4'h1, 16'h0103);
			@(posedge sys_clk) bsr <= 1'b1;
			repeat (6) @(posedge sys_clk);
			bsr <= 1'b0;
			pause(6);
			rd_reg("power_mgmt_ctrl_status", 4'h1, {7'h0, w[11] | w[12], 4'h0, w[14], 3'h0});
			rd_reg("status", 4'h2, {12'h0, w[11] | w[12], 1'b1, ~w[14], 1'b1});
			chk("irq", 16'h0, {15'h0, irq});
			wr_reg(4'h3, 16'h000F);
			pause(2);
			chk("irq", 16'h1, {15'h0, irq});
			wr_reg(4'h2, 16'h000F);
			pause(2);
			chk("irq", 16'h0, {15'h0, irq});
		end
		do_reset(1'b0, 16'hFFFF, 4'h0);
		chk("clk_rate", 16'h0, {15'h0, slow});
		rd_reg("cap", 4'h0, 16'h0000);
		stop_test();
	end
endmodule : eeprom_config_word_decoder_bench
`default_nettype wire
